/* File: logic/tcp_pkg.sv */
// Purpose: Constants for the timer 2 compare port logic
// Assumes: 32-bit classic Wishbone, word-aligned registers
// Notes: Byte addresses below are all multiples of four
package tcp_pkg;
   localparam int ADR_W = 8;
   // Register byte addresses
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_COMPARE_CAPTURE_ENABLE = 8'h04;
   localparam logic [7:0] ADR_CH4 = 8'h08;
   localparam logic [7:0] ADR_SETM = 8'h0c;
   localparam logic [7:0] ADR_CLRM = 8'h10;
   localparam logic [7:0] ADR_SMSK = 8'h14;
   localparam logic [7:0] ADR_CMSK = 8'h18;
   localparam logic [7:0] ADR_P5 = 8'h1c;
   localparam logic [7:0] ADR_P1 = 8'h20;
   localparam logic [7:0] ADR_P1SH = 8'h24;
   localparam logic [7:0] ADR_CH0 = 8'h30;
   localparam logic [7:0] ADR_IRQS = 8'h40;
   localparam logic [7:0] ADR_IRQM = 8'h44;
   // Field positions
   localparam int CTRL_TIMER2_COMPARE_MODE_SELECT = 0;
   localparam int CH4_LOW = 0;
   localparam int CH4_HIGH = 1;
   localparam int CH4_COCO0 = 2;
   localparam int CH4_COCO1 = 3;
   localparam int CH4_CNT_LSB = 4;
   localparam int IRQ_SET = 0;
   localparam int IRQ_CLR = 1;
   localparam int IRQ_CH_LSB = 2;
   localparam int IRQ_W = 6;
   // Function field encodings
   localparam logic [1:0] FN_OFF = 2'h0;
   localparam logic [1:0] FN_CAP_EDGE = 2'h1;
   localparam logic [1:0] FN_CMP = 2'h2;
   localparam logic [1:0] FN_CAP_WR = 2'h3;
   localparam logic [1:0] COCO_MODE2 = 2'h3;
   // Reset values
   localparam logic [7:0] RST_PORT = 8'hff;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
endpackage

/* File: logic/tcp_compare.sv */
// Purpose: Timer 2 compare port logic: modes 0, 1 and 2 with registers
// Assumes: Timer 2 count and overflow come from logic on clk_i
// Notes: Port pins are split into input, output and output enable
// How it works
// - Mode 1, match active: port write updates both latches
// - Read-modify-write uses shadow latch only
// - Plain read returns physical pin level
// - Mode 2: match registers own port 5
// - Two 16-bit match registers against timer 2
// - Set match drives set-masked pins high
// - Clear match drives clear-masked pins low
// - CPU writes and reads port 5 still
// - Three-bit count picks participating port 5 pins
// - Simultaneous set and clear: set wins
// - Match interrupts raised even without mode 2
// - Channel 0 tied to timer 2, reloads
// - One bit selects compare mode 0/1
// - Two-bit function field per channel
// - Channels compare or capture; channel 0 reloads
// - Mode 1: latch takes shadow on match only
// - Mode 0: high on match, low overflow
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module tcp_compare
   import tcp_pkg::*;
#(
   parameter int NCH = 4
)(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Timer 2
   input wire logic [15:0] t2_count_i,
   input wire logic t2_ovf_i,
   output logic [15:0] reload_value_o,
   // Port 1 compare pins
   input wire logic [NCH-1:0] p1_pin_i,
   output logic [NCH-1:0] p1_o,
   output logic [NCH-1:0] p1_oe_o,
   // Fifth port pins
   input wire logic [7:0] p5_pin_i,
   output logic [7:0] p5_o,
   output logic [7:0] p5_oe_o,
   // Interrupt
   output logic irq_o
);
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
      merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic [7:0] pin_span(input logic [2:0] n);
      for (int i = 0; i < 8; i++)
         pin_span[i] = (3'(i) <= n);
   endfunction

   logic timer2_compare_mode_select;
   logic [7:0] compare_capture_enable;
   logic [7:0] ch4_cfg;
   logic [15:0] set_match_register;
   logic [15:0] clear_match_register;
   logic [7:0] set_mask;
   logic [7:0] clear_mask;
   logic [7:0] fifth_port;
   logic [NCH-1:0] p1_latch;
   logic [NCH-1:0] p1_shadow;
   logic [15:0] ch_reg [NCH];
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [7:0] p5_s1, p5_s2;
   logic [NCH-1:0] p1_s1, p1_s2, p1_s3;
   logic [IRQ_W-1:0] hit_q;

   // Bus strobes, acting at the edge that samples ack
   logic acc, wr;
   // Every request is acked one cycle later, no wait states
   assign acc = wb_cyc_i & wb_stb_i & wb_ack_o;
   assign wr = acc & wb_we_i;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
   end

   // Pin synchronisers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         p5_s1 <= RST_BYTE;
         p5_s2 <= RST_BYTE;
         // Pull-up level, so no false rising edge follows reset
         p1_s1 <= '1;
         p1_s2 <= '1;
         p1_s3 <= '1;
      end
      else
      begin
         p5_s1 <= p5_pin_i;
         p5_s2 <= p5_s1;
         p1_s1 <= p1_pin_i;
         p1_s2 <= p1_s1;
         p1_s3 <= p1_s2;
      end
   end

   // Match detection
   logic set_hit, clr_hit;
   logic [NCH-1:0] ch_hit, ch_cmp, wr_p1, wr_sh;
   assign set_hit = (t2_count_i == set_match_register);
   assign clr_hit = (t2_count_i == clear_match_register);
   assign wr_p1 = {NCH{wr & (wb_adr_i == ADR_P1) & wb_sel_i[0]}};
   assign wr_sh = {NCH{wr & (wb_adr_i == ADR_P1SH) & wb_sel_i[0]}};

   // Mode 2 needs channel 4 compare and both concurrent bits
   logic mode2;
   logic [7:0] span, set_eff, clr_eff;
   assign mode2 = ({ch4_cfg[CH4_HIGH], ch4_cfg[CH4_LOW]} == FN_CMP)
                  && ({ch4_cfg[CH4_COCO1], ch4_cfg[CH4_COCO0]} == COCO_MODE2);
   assign span = pin_span(ch4_cfg[CH4_CNT_LSB +: 3]);
   assign set_eff = set_mask & span;
   assign clr_eff = clear_mask & span;

   // Control registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         timer2_compare_mode_select <= 1'b0;
         compare_capture_enable <= RST_BYTE;
         ch4_cfg <= RST_BYTE;
         set_match_register <= RST_WORD;
         clear_match_register <= RST_WORD;
         set_mask <= RST_BYTE;
         clear_mask <= RST_BYTE;
         irq_mask <= '0;
      end
      else if (wr)
      begin
         if (wb_adr_i == ADR_CTRL && wb_sel_i[0])
            timer2_compare_mode_select <= wb_dat_i[CTRL_TIMER2_COMPARE_MODE_SELECT];
         if (wb_adr_i == ADR_COMPARE_CAPTURE_ENABLE && wb_sel_i[0])
            compare_capture_enable <= wb_dat_i[7:0];
         if (wb_adr_i == ADR_CH4 && wb_sel_i[0])
            ch4_cfg <= {1'b0, wb_dat_i[6:0]};
         if (wb_adr_i == ADR_SETM)
            set_match_register <= merge16(set_match_register, wb_dat_i, wb_sel_i);
         if (wb_adr_i == ADR_CLRM)
            clear_match_register <= merge16(clear_match_register, wb_dat_i, wb_sel_i);
         if (wb_adr_i == ADR_SMSK && wb_sel_i[0])
            set_mask <= wb_dat_i[7:0];
         if (wb_adr_i == ADR_CMSK && wb_sel_i[0])
            clear_mask <= wb_dat_i[7:0];
         if (wb_adr_i == ADR_IRQM && wb_sel_i[0])
            irq_mask <= wb_dat_i[IRQ_W-1:0];
      end
   end

   // Fifth port latch: match beats a same-cycle CPU write
   logic [7:0] next_fifth;
   always_comb
   begin
      next_fifth = fifth_port;
      if (wr && wb_adr_i == ADR_P5 && wb_sel_i[0])
         next_fifth = wb_dat_i[7:0];
      if (mode2)
      begin
         if (clr_hit)
            next_fifth = next_fifth & ~clr_eff;
         if (set_hit)
            next_fifth = next_fifth | set_eff;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fifth_port <= RST_PORT;
      else
         fifth_port <= next_fifth;
   end

   assign p5_o = fifth_port;
   assign p5_oe_o = mode2 ? span : 8'h00;

   // Channels 0..3
   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      logic [1:0] fn;
      logic cap;
      assign fn = compare_capture_enable[2*i +: 2];
      assign ch_cmp[i] = (fn == FN_CMP);
      assign ch_hit[i] = ch_cmp[i] & (t2_count_i == ch_reg[i]);
      assign cap = ((fn == FN_CAP_EDGE) & p1_s2[i] & ~p1_s3[i])
                   | ((fn == FN_CAP_WR) & wr & (wb_adr_i == ADR_CH0 + 8'(4*i)) & wb_sel_i[0]);

      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            ch_reg[i] <= RST_WORD;
         else if (cap)
            ch_reg[i] <= t2_count_i;
         else if (wr && wb_adr_i == ADR_CH0 + 8'(4*i))
            ch_reg[i] <= merge16(ch_reg[i], wb_dat_i, wb_sel_i);
      end

      // Shadow takes writes from both the port and its own alias
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            p1_shadow[i] <= 1'b1;
         else if (wr_p1[i] || wr_sh[i])
            p1_shadow[i] <= wb_dat_i[i];
      end

      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            p1_latch[i] <= 1'b1;
         else if (ch_cmp[i] && !timer2_compare_mode_select)
         begin
            if (ch_hit[i])
               p1_latch[i] <= 1'b1;
            else if (t2_ovf_i)
               p1_latch[i] <= 1'b0;
         end
         else if (ch_cmp[i])
         begin
            if (ch_hit[i] && wr_p1[i])
               p1_latch[i] <= wb_dat_i[i];
            else if (ch_hit[i])
               p1_latch[i] <= p1_shadow[i];
         end
         else if (wr_p1[i])
            p1_latch[i] <= wb_dat_i[i];
      end
   end

   assign p1_o = p1_latch;
   assign p1_oe_o = ch_cmp;
   assign reload_value_o = ch_reg[0];

   // Sticky interrupt status, set beats write-one clear
   logic [IRQ_W-1:0] hit_now, ev, w1c;
   assign hit_now = {ch_hit, clr_hit, set_hit};
   assign ev = hit_now & ~hit_q;
   assign w1c = (wr && wb_adr_i == ADR_IRQS && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hit_q <= '0;
         irq_stat <= '0;
      end
      else
      begin
         hit_q <= hit_now;
         irq_stat <= (irq_stat & ~w1c) | ev;
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

   // Read data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= '0;
      else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
         wb_dat_o <= '0;
         unique case (wb_adr_i)
            ADR_CTRL: wb_dat_o[CTRL_TIMER2_COMPARE_MODE_SELECT] <= timer2_compare_mode_select;
            ADR_COMPARE_CAPTURE_ENABLE: wb_dat_o[7:0] <= compare_capture_enable;
            ADR_CH4: wb_dat_o[7:0] <= ch4_cfg;
            ADR_SETM: wb_dat_o[15:0] <= set_match_register;
            ADR_CLRM: wb_dat_o[15:0] <= clear_match_register;
            ADR_SMSK: wb_dat_o[7:0] <= set_mask;
            ADR_CMSK: wb_dat_o[7:0] <= clear_mask;
            ADR_P5: wb_dat_o[7:0] <= p5_s2;
            ADR_P1: wb_dat_o[NCH-1:0] <= p1_s2;
            ADR_P1SH: wb_dat_o[NCH-1:0] <= p1_shadow;
            ADR_IRQS: wb_dat_o[IRQ_W-1:0] <= irq_stat;
            ADR_IRQM: wb_dat_o[IRQ_W-1:0] <= irq_mask;
            default:
            begin
               for (int k = 0; k < NCH; k++)
                  if (wb_adr_i == ADR_CH0 + 8'(4*k))
                     wb_dat_o[15:0] <= ch_reg[k];
            end
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence set_only_s;
      mode2 && set_hit && !clr_hit;
   endsequence
   sequence both_s;
      mode2 && set_hit && clr_hit;
   endsequence

   set_pins_a: assert property (set_only_s |=> (p5_o & set_eff) == set_eff)
      else $error("set match did not raise masked pins");
   clear_pins_a: assert property (mode2 && clr_hit && !set_hit |=> (p5_o & $past(clr_eff)) == 8'h00)
      else $error("clear match did not lower masked pins");
   set_wins_a: assert property (both_s |=> (p5_o & $past(set_eff)) == $past(set_eff))
      else $error("set did not win over clear");
   shadow_hold_a: assert property (ch_cmp[1] && timer2_compare_mode_select && !ch_hit[1] ##1 ch_cmp[1] && timer2_compare_mode_select
                                   |-> $stable(p1_latch[1]))
      else $error("mode 1 latch moved without match");
   mode0_high_a: assert property (ch_cmp[2] && !timer2_compare_mode_select && ch_hit[2] |=> p1_o[2])
      else $error("mode 0 output not high after match");
   mode0_low_a: assert property (ch_cmp[2] && !timer2_compare_mode_select && !ch_hit[2] && t2_ovf_i |=> !p1_o[2])
      else $error("mode 0 output not low after overflow");
   // Both latches must carry the written bit, not merely agree
   transparent_a: assert property (ch_cmp[1] && timer2_compare_mode_select && ch_hit[1] && wr_p1[1]
                                   |=> p1_latch[1] == $past(wb_dat_i[1]) && p1_shadow[1] == $past(wb_dat_i[1]))
      else $error("latches differ after write during match");
   irq_only_a: assert property (!mode2 && set_hit && !hit_q[IRQ_SET] |=> irq_stat[IRQ_SET])
      else $error("set match raised no status");
   pin_read_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == ADR_P1
                                |=> wb_ack_o && wb_dat_o[NCH-1:0] == $past(p1_s2))
      else $error("port read did not return pins");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over two cycles");
endmodule
`default_nettype wire

/* File: sim/tcp_pins.sv */
// Purpose: Port pin model for port 1 and the fifth port
// Assumes: Pins have pull-ups and float high when undriven
// Notes: Bench may pull undriven port 1 pins to a level
`timescale 1ns/1ns
`default_nettype none
module tcp_pins (
   // Block side
   input wire logic [3:0] p1_drv_i,
   input wire logic [3:0] p1_en_i,
   input wire logic [7:0] p5_drv_i,
   input wire logic [7:0] p5_en_i,
   // Outside driver
   input wire logic ext_en_i,
   input wire logic ext_val_i,
   // Pin levels
   output logic [3:0] p1_pin_o,
   output logic [7:0] p5_pin_o
);
   // The outside driver only yields to the block, never fights it
   assign p1_pin_o = (p1_en_i & p1_drv_i) | (~p1_en_i & {4{~ext_en_i | ext_val_i}});
   assign p5_pin_o = (p5_en_i & p5_drv_i) | ~p5_en_i;
endmodule
`default_nettype wire

/* File: sim/timer2_compare_port_logic_test.sv */
// Purpose: Self-checking bench for the timer 2 compare port logic
// Assumes: Wishbone ack arrives before the watchdog fires
// Notes: Idle timer count is ffff, above every register value used
`timescale 1ns/1ns
`default_nettype none
module timer2_compare_port_logic_test import tcp_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, irq_o;
   logic t2_ovf_i = 1'b0;
   logic ext_en = 1'b0;
   logic ext_val = 1'b1;
   logic [15:0] t2_count_i = 16'hffff;
   logic [15:0] reload_value_o, s, r;
   logic [3:0] p1_pin_i, p1_o, p1_oe_o;
   logic [7:0] p5_pin_i, p5_o, p5_oe_o, sm, cm, span, p5e;
   int failures = 0;
   int cmp_count = 0;

   always #50 clk_i = ~clk_i;

   tcp_compare i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .t2_count_i(t2_count_i), .t2_ovf_i(t2_ovf_i),
      .reload_value_o(reload_value_o), .p1_pin_i(p1_pin_i), .p1_o(p1_o), .p1_oe_o(p1_oe_o),
      .p5_pin_i(p5_pin_i), .p5_o(p5_o), .p5_oe_o(p5_oe_o), .irq_o(irq_o));
   tcp_pins i_pins (.p1_drv_i(p1_o), .p1_en_i(p1_oe_o), .p5_drv_i(p5_o), .p5_en_i(p5_oe_o),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .p1_pin_o(p1_pin_i), .p5_pin_o(p5_pin_i));

   task automatic give_verdict;
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      // No cycle count assumed; only the watchdog ends a hung wait
      do
      begin
         @(posedge clk_i);
      end
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      #1;
   endtask

   // Count sits on v for one cycle; outputs checked after the match edge
   task automatic tick(input logic [15:0] v, input logic ovf);
      @(posedge clk_i);
      t2_count_i <= v;
      t2_ovf_i <= ovf;
      @(posedge clk_i);
      t2_count_i <= 16'hffff;
      t2_ovf_i <= 1'b0;
      #1;
   endtask

   initial
   begin
      #3000000;
      failures++;
      give_verdict();
   end

   initial
   begin
      s = 16'($urandom(36455));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      ext_en <= 1'b1;
      ext_val <= 1'b0;
      repeat (3) @(posedge clk_i);
      wb(0, ADR_P1, 0);
      chk(rd, 32'h0);
      @(posedge clk_i);
      ext_en <= 1'b0;
      wb(0, 8'h2c, 0);
      chk(rd, 32'h0);
      chk(p5_oe_o, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         s = 16'h0100 + 16'($urandom_range(0, 16'h3fff));
         sm = 8'($urandom);
         cm = 8'($urandom);
         p5e = 8'($urandom);
         span = 8'((2 << k) - 1);
         wb(1, ADR_CH4, 32'((k << 4) | 4'he));
         wb(1, ADR_SETM, {16'hffff, s});
         wb(0, ADR_SETM, 0);
         chk(rd, {16'h0, s});
         wb(1, ADR_CLRM, {16'h0, s + 16'h4000});
         wb(1, ADR_SMSK, {24'h0, sm});
         wb(1, ADR_CMSK, {24'h0, cm});
         wb(1, ADR_P5, {24'h0, p5e});
         chk(p5_o, p5e);
         chk(p5_oe_o, span);
         tick(s, 1'b0);
         p5e = p5e | (sm & span);
         chk(p5_o, p5e);
         tick(s + 16'h4000, 1'b0);
         p5e = p5e & ~(cm & span);
         chk(p5_o, p5e);
         repeat (3) @(posedge clk_i);
         wb(0, ADR_P5, 0);
         chk(rd, {24'h0, p5e | ~span});
      end
      wb(1, ADR_CLRM, {16'h0, s});
      wb(1, ADR_P5, 0);
      tick(s, 1'b0);
      chk(p5_o, sm);
      wb(1, ADR_CH4, 0);
      chk(p5_oe_o, 8'h00);
      wb(1, ADR_IRQS, 32'h3f);
      wb(1, ADR_IRQM, 32'h1);
      wb(1, ADR_P5, 0);
      tick(s, 1'b0);
      chk(p5_o, 8'h00);
      wb(0, ADR_IRQS, 0);
      chk(rd, 32'h3);
      chk(irq_o, 1'b1);
      wb(1, ADR_IRQS, 32'h1);
      wb(0, ADR_IRQS, 0);
      chk(rd, 32'h2);
      chk(irq_o, 1'b0);
      r = s + 16'h0011;
      wb(1, ADR_CTRL, 1);
      wb(1, ADR_COMPARE_CAPTURE_ENABLE, 8'h08);
      wb(1, ADR_CH0 + 8'h04, {16'h0, r});
      chk(p1_oe_o, 4'h2);
      wb(1, ADR_P1, 0);
      chk(p1_o[1], 1'b1);
      tick(r, 1'b0);
      chk(p1_o[1], 1'b0);
      wb(1, ADR_P1SH, 32'h2);
      wb(0, ADR_P1SH, 0);
      chk(rd[1], 1'b1);
      chk(p1_o[1], 1'b0);
      @(posedge clk_i);
      t2_count_i <= r;
      wb(1, ADR_P1, 0);
      chk(p1_o[1], 1'b0);
      @(posedge clk_i);
      t2_count_i <= 16'hffff;
      wb(1, ADR_CTRL, 0);
      wb(1, ADR_COMPARE_CAPTURE_ENABLE, 8'h20);
      wb(1, ADR_CH0 + 8'h08, {16'h0, r});
      tick(16'hffff, 1'b1);
      chk(p1_o[2], 1'b0);
      tick(r, 1'b0);
      chk(p1_o[2], 1'b1);
      wb(1, ADR_P1, 0);
      chk(p1_o[2], 1'b1);
      wb(1, ADR_CH0, {16'h0, s});
      chk(reload_value_o, s);
      // Capture on rising pin edge for channel 0, on write for channel 3
      wb(1, ADR_COMPARE_CAPTURE_ENABLE, 8'hc1);
      @(posedge clk_i);
      t2_count_i <= r;
      ext_en <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_val <= 1'b1;
      repeat (6) @(posedge clk_i);
      wb(0, ADR_CH0, 0);
      chk(rd, {16'h0, r});
      wb(1, ADR_CH0 + 8'h0c, 0);
      wb(0, ADR_CH0 + 8'h0c, 0);
      chk(rd, {16'h0, r});
      give_verdict();
   end
endmodule
`default_nettype wire
